// [hw/fpd_top.sv]
// Purpose: decode and execute control-move, multiply and negate over axi4-lite
// Assumes: software writes the two instruction words, the converted source
//  operand (extended format) and then the go bit; memory side moves go via XFER
// Notes: mantissa product keeps the top 64 bits only; rounding is truncation
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`default_nettype none
module fpd_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic busy_out
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic have_aw;
		logic have_w;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		fpd_pkg::fpd_state_type state;
		logic [31:0] word;
		logic [31:0] src_hi;
		logic [31:0] src_lo;
		logic [31:0] src_exp;
		logic [31:0] fpcr;
		logic [31:0] fpsr;
		logic [31:0] fpiar;
		logic [7:0][79:0] fpreg;
		logic [3:0] status;
		logic [79:0] result;
		logic [2:0] xfer_left;
		logic busy;
	} fpd_core_type;
	fpd_core_type cur_ff;
	fpd_core_type nxt_ff;
	// ------------------------------------------------------------
	// instruction fields
	// ------------------------------------------------------------
	logic [15:0] w1;
	logic [15:0] w2;
	logic is_line;
	logic is_ctrl;
	logic rm;
	logic dir;
	logic [2:0] sel;
	logic [2:0] spec;
	logic [2:0] dst;
	logic [6:0] opm;
	logic ea_legal;
	always_comb begin
		w1 = cur_ff.word[31:16];
		w2 = cur_ff.word[15:0];
		is_line = (w1[fpd_pkg::W1_LINE_HI:fpd_pkg::W1_LINE_LO] == fpd_pkg::W1_LINE);
		is_ctrl = w2[fpd_pkg::W2_CTRL_MOVE];
		rm = w2[fpd_pkg::W2_RM];
		dir = w2[fpd_pkg::W2_DIR];
		sel = {w2[fpd_pkg::SEL_FPCR], w2[fpd_pkg::SEL_FPSR], w2[fpd_pkg::SEL_FPIAR]};
		spec = w2[fpd_pkg::W2_SPEC_HI:fpd_pkg::W2_SPEC_LO];
		dst = w2[fpd_pkg::W2_DST_HI:fpd_pkg::W2_DST_LO];
		opm = w2[fpd_pkg::W2_OP_HI:fpd_pkg::W2_OP_LO];
	end
	fpd_ea_check u_ea (
		.mode_in(w1[fpd_pkg::EA_MODE_HI:fpd_pkg::EA_MODE_LO]),
		.reg_in(w1[fpd_pkg::EA_REG_HI:fpd_pkg::EA_REG_LO]),
		.is_ctrl_in(is_ctrl),
		.to_mem_in(dir),
		.sel_in(sel),
		.fmt_in(spec),
		.legal_out(ea_legal)
	);
	// ------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------
	logic [79:0] src_x;
	logic [79:0] dst_x;
	logic s_zero;
	logic s_inf;
	logic d_zero;
	logic d_inf;
	logic [127:0] prod;
	logic [16:0] exp_sum;
	logic [79:0] mul_res;
	logic [79:0] neg_res;
	logic is_mul;
	logic is_neg;
	logic [1:0] prec;
	logic zero_inf;
	logic [63:0] mant_n;
	logic [15:0] exp_n;
	logic [63:0] mant_s;
	always_comb begin
		src_x = rm ? {cur_ff.src_exp[15:0], cur_ff.src_hi, cur_ff.src_lo} : cur_ff.fpreg[spec];
		dst_x = cur_ff.fpreg[dst];
		s_zero = (src_x[78:64] == 15'h0) && (src_x[63:0] == 64'h0);
		d_zero = (dst_x[78:64] == 15'h0) && (dst_x[63:0] == 64'h0);
		s_inf = (src_x[78:64] == fpd_pkg::EXP_MAX);
		d_inf = (dst_x[78:64] == fpd_pkg::EXP_MAX);
		is_mul = (opm == fpd_pkg::OP_MUL) || (opm == fpd_pkg::OP_MUL_S) || (opm == fpd_pkg::OP_MUL_D);
		is_neg = (opm == fpd_pkg::OP_NEG) || (opm == fpd_pkg::OP_NEG_S) || (opm == fpd_pkg::OP_NEG_D);
		prec = cur_ff.fpcr[fpd_pkg::FPCR_PREC_HI:fpd_pkg::FPCR_PREC_LO];
		if ((opm == fpd_pkg::OP_MUL_S) || (opm == fpd_pkg::OP_NEG_S)) begin
			prec = fpd_pkg::PREC_SGL;
		end else if ((opm == fpd_pkg::OP_MUL_D) || (opm == fpd_pkg::OP_NEG_D)) begin
			prec = fpd_pkg::PREC_DBL;
		end
		zero_inf = (s_zero && d_inf) || (s_inf && d_zero);
		prod = src_x[63:0] * dst_x[63:0];
		exp_sum = {2'b00, src_x[78:64]} + {2'b00, dst_x[78:64]} - 17'h3FFE;
		mant_n = prod[127] ? prod[127:64] : prod[126:63];
		exp_n = prod[127] ? exp_sum[15:0] : exp_sum[15:0] - 16'h1;
		// truncating to the selected precision keeps the low mantissa bits clear
		mant_s = src_x[63:0];
		if (prec == fpd_pkg::PREC_SGL) begin
			mant_n = {mant_n[63:40], 40'h0};
			mant_s = {src_x[63:40], 40'h0};
		end else if (prec == fpd_pkg::PREC_DBL) begin
			mant_n = {mant_n[63:11], 11'h0};
			mant_s = {src_x[63:11], 11'h0};
		end
		if (zero_inf) begin
			mul_res = {1'b0, fpd_pkg::EXP_MAX, fpd_pkg::NAN_MANT};
		end else if (s_inf || d_inf) begin
			mul_res = {src_x[79] ^ dst_x[79], fpd_pkg::EXP_MAX, 64'h0};
		end else if (s_zero || d_zero) begin
			mul_res = {src_x[79] ^ dst_x[79], 79'h0};
		end else begin
			mul_res = {src_x[79] ^ dst_x[79], exp_n[14:0], mant_n};
		end
		neg_res = {~src_x[79], src_x[78:64], mant_s};
	end
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic wr_go;
	logic illegal;
	logic [31:0] rd_val;
	logic [2:0] left_next;
	always_comb begin
		nxt_ff = cur_ff;
		wr_go = 1'b0;
		left_next = 3'h0;
		illegal = !is_line || (rm && !ea_legal) || (is_ctrl && !ea_legal) ||
			(!is_ctrl && !is_mul && !is_neg) || (is_ctrl && (sel == 3'h0));
		// write channel: address and data in either order
		if (s_axi_awvalid && cur_ff.awready) begin
			nxt_ff.have_aw = 1'b1;
			nxt_ff.awaddr = s_axi_awaddr;
			nxt_ff.awready = 1'b0;
		end
		if (s_axi_wvalid && cur_ff.wready) begin
			nxt_ff.have_w = 1'b1;
			nxt_ff.wdata = s_axi_wdata;
			nxt_ff.wstrb = s_axi_wstrb;
			nxt_ff.wready = 1'b0;
		end
		if (cur_ff.have_aw && cur_ff.have_w && !cur_ff.bvalid) begin
			nxt_ff.bvalid = 1'b1;
			nxt_ff.bresp = fpd_pkg::BRESP_OKAY;
			nxt_ff.have_aw = 1'b0;
			nxt_ff.have_w = 1'b0;
			unique case (cur_ff.awaddr)
				fpd_pkg::OFF_WORD: nxt_ff.word = cur_ff.wdata;
				fpd_pkg::OFF_SRC_HI: nxt_ff.src_hi = cur_ff.wdata;
				fpd_pkg::OFF_SRC_LO: nxt_ff.src_lo = cur_ff.wdata;
				fpd_pkg::OFF_SRC_EXP: nxt_ff.src_exp = cur_ff.wdata;
				fpd_pkg::OFF_FPCR: nxt_ff.fpcr = cur_ff.wdata;
				fpd_pkg::OFF_FPSR: nxt_ff.fpsr = cur_ff.wdata;
				fpd_pkg::OFF_FPIAR: nxt_ff.fpiar = cur_ff.wdata;
				fpd_pkg::OFF_CTRL: wr_go = cur_ff.wdata[0];
				fpd_pkg::OFF_XFER: wr_go = 1'b0;
				fpd_pkg::OFF_STATUS, fpd_pkg::OFF_RES_HI, fpd_pkg::OFF_RES_LO, fpd_pkg::OFF_RES_EXP: wr_go = 1'b0;
				default: nxt_ff.bresp = fpd_pkg::BRESP_SLVERR;
			endcase
			if (cur_ff.busy && cur_ff.awaddr != fpd_pkg::OFF_XFER && cur_ff.awaddr != fpd_pkg::OFF_STATUS) begin
				nxt_ff.bresp = fpd_pkg::BRESP_SLVERR;
			end
		end
		if (cur_ff.bvalid && s_axi_bready) begin
			nxt_ff.bvalid = 1'b0;
			nxt_ff.awready = 1'b1;
			nxt_ff.wready = 1'b1;
		end
		// read channel
		unique case (s_axi_araddr)
			fpd_pkg::OFF_CTRL: rd_val = {31'h0, cur_ff.busy};
			fpd_pkg::OFF_WORD: rd_val = cur_ff.word;
			fpd_pkg::OFF_SRC_HI: rd_val = cur_ff.src_hi;
			fpd_pkg::OFF_SRC_LO: rd_val = cur_ff.src_lo;
			fpd_pkg::OFF_SRC_EXP: rd_val = cur_ff.src_exp;
			fpd_pkg::OFF_STATUS: rd_val = {28'h0, cur_ff.status};
			fpd_pkg::OFF_FPCR: rd_val = cur_ff.fpcr;
			fpd_pkg::OFF_FPSR: rd_val = cur_ff.fpsr;
			fpd_pkg::OFF_FPIAR: rd_val = cur_ff.fpiar;
			fpd_pkg::OFF_RES_HI: rd_val = cur_ff.result[63:32];
			fpd_pkg::OFF_RES_LO: rd_val = cur_ff.result[31:0];
			fpd_pkg::OFF_RES_EXP: rd_val = {16'h0, cur_ff.result[79:64]};
			fpd_pkg::OFF_XFER: rd_val = {29'h0, cur_ff.xfer_left};
			default: rd_val = fpd_pkg::RESP_OKAY;
		endcase
		if (s_axi_arvalid && cur_ff.arready) begin
			nxt_ff.arready = 1'b0;
			nxt_ff.rvalid = 1'b1;
			nxt_ff.rdata = rd_val;
			nxt_ff.rresp = (rd_val == fpd_pkg::RESP_OKAY && s_axi_araddr > fpd_pkg::OFF_XFER) ?
				fpd_pkg::BRESP_SLVERR : fpd_pkg::BRESP_OKAY;
		end
		if (cur_ff.rvalid && s_axi_rready) begin
			nxt_ff.rvalid = 1'b0;
			nxt_ff.arready = 1'b1;
		end
		// sequencer
		unique case (cur_ff.state)
			fpd_pkg::ST_IDLE: begin
				if (wr_go) begin
					nxt_ff.state = fpd_pkg::ST_EXEC;
					nxt_ff.busy = 1'b1;
					nxt_ff.status = 4'h0;
				end
			end
			fpd_pkg::ST_EXEC: begin
				nxt_ff.state = fpd_pkg::ST_IDLE;
				nxt_ff.busy = 1'b0;
				nxt_ff.status[fpd_pkg::ST_DONE] = 1'b1;
				if (illegal) begin
					nxt_ff.status[fpd_pkg::ST_ILLEGAL] = 1'b1;
				end else if (is_ctrl) begin
					// one word moves per XFER write, control first then status then address
					nxt_ff.state = fpd_pkg::ST_XFER;
					nxt_ff.busy = 1'b1;
					nxt_ff.status[fpd_pkg::ST_DONE] = 1'b0;
					nxt_ff.xfer_left = sel;
				end else if (rm && spec == fpd_pkg::FMT_PACKED) begin
					nxt_ff.status[fpd_pkg::ST_UNIMP] = 1'b1;
				end else if (is_mul) begin
					nxt_ff.fpreg[dst] = mul_res;
					nxt_ff.result = mul_res;
					nxt_ff.status[fpd_pkg::ST_NAN] = zero_inf;
					nxt_ff.fpsr[fpd_pkg::EXC_INVALID] = zero_inf;
					nxt_ff.fpsr[fpd_pkg::EXC_UNORD] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_DZ] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
				end else begin
					nxt_ff.fpreg[dst] = neg_res;
					nxt_ff.result = neg_res;
					nxt_ff.fpsr[fpd_pkg::EXC_UNORD] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_INVALID] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_OVERFLOW_FLAG] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_DZ] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_INEXACT_RESULT_FLAG] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
					nxt_ff.fpsr[fpd_pkg::EXC_UNDERFLOW_FLAG] = rm && (spec == fpd_pkg::FMT_EXT) &&
						(src_x[78:64] == 15'h0) && (src_x[63:0] != 64'h0);
				end
			end
			fpd_pkg::ST_XFER: begin
				// each XFER write moves the highest selected register in order
				if (cur_ff.have_aw && cur_ff.have_w && !cur_ff.bvalid && cur_ff.awaddr == fpd_pkg::OFF_XFER) begin
					if (cur_ff.xfer_left[2]) begin
						left_next = {1'b0, cur_ff.xfer_left[1:0]};
						if (!dir) nxt_ff.fpcr = cur_ff.wdata;
						nxt_ff.result = {48'h0, cur_ff.fpcr};
					end else if (cur_ff.xfer_left[1]) begin
						left_next = {2'b00, cur_ff.xfer_left[0]};
						if (!dir) nxt_ff.fpsr = cur_ff.wdata;
						nxt_ff.result = {48'h0, cur_ff.fpsr};
					end else begin
						left_next = 3'h0;
						if (!dir) nxt_ff.fpiar = cur_ff.wdata;
						nxt_ff.result = {48'h0, cur_ff.fpiar};
					end
					nxt_ff.xfer_left = left_next;
					if (left_next == 3'h0) begin
						nxt_ff.state = fpd_pkg::ST_IDLE;
						nxt_ff.busy = 1'b0;
						nxt_ff.status[fpd_pkg::ST_DONE] = 1'b1;
					end
				end
			end
			default: nxt_ff.state = fpd_pkg::ST_IDLE;
		endcase
		// quotient byte is held during execute; control-move loads and FPSR register writes can change it
		nxt_ff.fpsr[fpd_pkg::QUOT_HI:fpd_pkg::QUOT_LO] = (cur_ff.state == fpd_pkg::ST_XFER || !cur_ff.busy) ?
			nxt_ff.fpsr[fpd_pkg::QUOT_HI:fpd_pkg::QUOT_LO] : cur_ff.fpsr[fpd_pkg::QUOT_HI:fpd_pkg::QUOT_LO];
		if (rst_in) begin
			nxt_ff = '0;
			nxt_ff.awready = 1'b1;
			nxt_ff.wready = 1'b1;
			nxt_ff.arready = 1'b1;
			nxt_ff.state = fpd_pkg::ST_IDLE;
		end
	end
	always_ff @(posedge clk_in) begin
		cur_ff <= nxt_ff;
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb begin
		s_axi_awready = cur_ff.awready;
		s_axi_wready = cur_ff.wready;
		s_axi_bvalid = cur_ff.bvalid;
		s_axi_bresp = cur_ff.bresp;
		s_axi_arready = cur_ff.arready;
		s_axi_rvalid = cur_ff.rvalid;
		s_axi_rdata = cur_ff.rdata;
		s_axi_rresp = cur_ff.rresp;
		busy_out = cur_ff.busy;
	end
endmodule
`default_nettype wire

// [inc/fpd_pkg.sv]
// Purpose: shared constants for the fp control-move / multiply / negate decoder
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes: offsets are byte addresses of aligned words
`default_nettype none
package fpd_pkg;
	// register map
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_WORD = 8'h04;
	localparam logic [7:0] OFF_SRC_HI = 8'h08;
	localparam logic [7:0] OFF_SRC_LO = 8'h0C;
	localparam logic [7:0] OFF_SRC_EXP = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_FPCR = 8'h18;
	localparam logic [7:0] OFF_FPSR = 8'h1C;
	localparam logic [7:0] OFF_FPIAR = 8'h20;
	localparam logic [7:0] OFF_RES_HI = 8'h24;
	localparam logic [7:0] OFF_RES_LO = 8'h28;
	localparam logic [7:0] OFF_RES_EXP = 8'h2C;
	localparam logic [7:0] OFF_XFER = 8'h30;
	// first instruction word
	localparam int W1_LINE_HI = 15;
	localparam int W1_LINE_LO = 12;
	localparam logic [3:0] W1_LINE = 4'hF;
	localparam int W1_ID_HI = 11;
	localparam int W1_ID_LO = 9;
	localparam int EA_MODE_HI = 5;
	localparam int EA_MODE_LO = 3;
	localparam int EA_REG_HI = 2;
	localparam int EA_REG_LO = 0;
	// second instruction word
	localparam int W2_CTRL_MOVE = 15;
	localparam int W2_RM = 14;
	localparam int W2_DIR = 13;
	localparam int W2_SPEC_HI = 12;
	localparam int W2_SPEC_LO = 10;
	localparam int W2_DST_HI = 9;
	localparam int W2_DST_LO = 7;
	localparam int W2_OP_HI = 6;
	localparam int W2_OP_LO = 0;
	localparam int SEL_FPCR = 12;
	localparam int SEL_FPSR = 11;
	localparam int SEL_FPIAR = 10;
	// addressing modes
	localparam logic [2:0] MODE_DREG = 3'h0;
	localparam logic [2:0] MODE_AREG = 3'h1;
	localparam logic [2:0] MODE_PREDEC = 3'h4;
	localparam logic [2:0] MODE_POSTINC = 3'h3;
	localparam logic [2:0] MODE_EXT = 3'h7;
	localparam logic [2:0] REG_ABS_W = 3'h0;
	localparam logic [2:0] REG_ABS_L = 3'h1;
	localparam logic [2:0] REG_IMM = 3'h4;
	localparam logic [2:0] REG_PC_D16 = 3'h2;
	localparam logic [2:0] REG_PC_IDX = 3'h3;
	// opmodes
	localparam logic [6:0] OP_MUL = 7'h23;
	localparam logic [6:0] OP_MUL_S = 7'h63;
	localparam logic [6:0] OP_MUL_D = 7'h67;
	localparam logic [6:0] OP_NEG = 7'h1A;
	localparam logic [6:0] OP_NEG_S = 7'h5A;
	localparam logic [6:0] OP_NEG_D = 7'h5E;
	// source formats
	localparam logic [2:0] FMT_LONG = 3'h0;
	localparam logic [2:0] FMT_SINGLE = 3'h1;
	localparam logic [2:0] FMT_EXT = 3'h2;
	localparam logic [2:0] FMT_PACKED = 3'h3;
	localparam logic [2:0] FMT_WORD = 3'h4;
	localparam logic [2:0] FMT_DOUBLE = 3'h5;
	localparam logic [2:0] FMT_BYTE = 3'h6;
	// rounding precision codes
	localparam logic [1:0] PREC_EXT = 2'h0;
	localparam logic [1:0] PREC_SGL = 2'h1;
	localparam logic [1:0] PREC_DBL = 2'h2;
	localparam int FPCR_PREC_HI = 7;
	localparam int FPCR_PREC_LO = 6;
	// status register exception byte and quotient byte bits
	localparam int EXC_UNORD = 15;
	localparam int EXC_INVALID = 13;
	localparam int EXC_OVERFLOW_FLAG = 12;
	localparam int EXC_UNDERFLOW_FLAG = 11;
	localparam int EXC_DZ = 10;
	localparam int EXC_INEXACT_RESULT_FLAG = 9;
	localparam int EXC_INEXACT_DECIMAL_INPUT_FLAG = 8;
	localparam int QUOT_HI = 23;
	localparam int QUOT_LO = 16;
	// decode status register bits
	localparam int ST_DONE = 0;
	localparam int ST_ILLEGAL = 1;
	localparam int ST_UNIMP = 2;
	localparam int ST_NAN = 3;
	// extended format and bus response values
	localparam logic [14:0] EXP_MAX = 15'h7FFF;
	localparam logic [63:0] NAN_MANT = 64'hFFFFFFFFFFFFFFFF;
	localparam logic [31:0] RESP_OKAY = 32'h0;
	localparam logic [1:0] BRESP_OKAY = 2'h0;
	localparam logic [1:0] BRESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_XFER = 2'b10
	} fpd_state_type;
endpackage
`default_nettype wire

// [hw/fpd_ea_check.sv]
// Purpose: legality of an effective address for one instruction class
// Assumes: mode/reg from instruction word 1
// Notes: pure combinational, used by the decoder
`default_nettype none
module fpd_ea_check (
	input wire logic [2:0] mode_in,
	input wire logic [2:0] reg_in,
	input wire logic is_ctrl_in,
	input wire logic to_mem_in,
	input wire logic [2:0] sel_in,
	input wire logic [2:0] fmt_in,
	output logic legal_out
);
	logic one_sel;
	logic only_iar;
	logic pc_or_imm;
	logic abs_ok;
	always_comb begin
		one_sel = (sel_in == 3'h1) || (sel_in == 3'h2) || (sel_in == 3'h4);
		only_iar = (sel_in == 3'h1);
		abs_ok = (mode_in == fpd_pkg::MODE_EXT) &&
			((reg_in == fpd_pkg::REG_ABS_W) || (reg_in == fpd_pkg::REG_ABS_L));
		pc_or_imm = (mode_in == fpd_pkg::MODE_EXT) && ((reg_in == fpd_pkg::REG_IMM) ||
			(reg_in == fpd_pkg::REG_PC_D16) || (reg_in == fpd_pkg::REG_PC_IDX));
		legal_out = 1'b0;
		if (is_ctrl_in) begin
			unique case (mode_in)
				fpd_pkg::MODE_DREG: legal_out = one_sel;
				fpd_pkg::MODE_AREG: legal_out = only_iar;
				fpd_pkg::MODE_EXT: legal_out = to_mem_in ? abs_ok : (abs_ok || pc_or_imm);
				fpd_pkg::MODE_POSTINC: legal_out = !to_mem_in;
				fpd_pkg::MODE_PREDEC: legal_out = to_mem_in;
				default: legal_out = 1'b1;
			endcase
		end else begin
			unique case (mode_in)
				fpd_pkg::MODE_DREG: legal_out = (fmt_in == fpd_pkg::FMT_BYTE) || (fmt_in == fpd_pkg::FMT_WORD) ||
					(fmt_in == fpd_pkg::FMT_LONG) || (fmt_in == fpd_pkg::FMT_SINGLE);
				fpd_pkg::MODE_AREG: legal_out = 1'b0;
				fpd_pkg::MODE_EXT: legal_out = abs_ok || pc_or_imm;
				default: legal_out = 1'b1;
			endcase
		end
	end
endmodule
`default_nettype wire

// [sim/fpd_top_assertions.sv]
// Purpose: handshake and refusal checks on the decoder register port
// Assumes: one clock, synchronous active-high reset
// Notes: decode results are judged by the bench; these guard timing
`default_nettype none
module fpd_top_chk (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic busy_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer not two cycles after take");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not next cycle");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	rd_refuse_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h30
		|=> s_axi_rresp == fpd_pkg::BRESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read not refused");
	wr_refuse_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& s_axi_awaddr > 8'h30 |-> ##2 s_axi_bresp == fpd_pkg::BRESP_SLVERR) else $error("bad write not refused");
	aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("address ready too soon");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	go_busy_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !busy_out
		&& s_axi_awaddr == fpd_pkg::OFF_CTRL && s_axi_wdata[0] |-> ##[1:3] busy_out) else $error("start ignored");
endmodule
bind fpd_top fpd_top_chk chk_u (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .busy_out(busy_out));
`default_nettype wire

// [sim/fpd_iu_model.sv]
// Purpose: integer-unit side, builds the two instruction words
// Assumes: coprocessor id 1 (arbitrary choice)
// Notes: fields are packed as given, so illegal encodings are produced too
`default_nettype none
module fpd_iu_model;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// encoders
	// ----------------------------------------
	function automatic logic [31:0] arith(input logic rm, input logic [2:0] spec, input logic [2:0] dst,
		input logic [6:0] op, input logic [2:0] md, input logic [2:0] rg);
		logic [5:0] ea;
		ea = rm ? {md, rg} : 6'h00;
		return {4'hF, 3'h1, 3'h0, ea, 1'b0, rm, 1'b0, spec, dst, op};
	endfunction
	function automatic logic [31:0] ctrl(input logic dr, input logic [2:0] mask, input logic [2:0] md,
		input logic [2:0] rg);
		// an empty mask is never issued
		return {4'hF, 3'h1, 3'h0, md, rg, 1'b1, 1'b0, dr, mask, 10'h000};
	endfunction
endmodule
`default_nettype wire

// [sim/test_fp_ctrl_move_mul_neg_decode.sv]
// Purpose: register-level tests of decode, multiply, negate and control moves
// Assumes: source already in extended form, data registers zero after reset
// Notes: rounding modelled as truncation, as the block does
`default_nettype none
module test_fp_ctrl_move_mul_neg_decode;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0, rst_in = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_q;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, busy_out;
	logic [1:0] bresp, rresp, bresp_q, rr_q;
	int err_count = 0, total_checks = 0;
	logic [6:0] n_op [6] = '{fpd_pkg::OP_NEG, fpd_pkg::OP_NEG_S, fpd_pkg::OP_NEG_D, fpd_pkg::OP_NEG,
		fpd_pkg::OP_NEG, fpd_pkg::OP_NEG};
	logic [15:0] n_ex [6] = '{16'h3FFF, 16'hBFFF, 16'h4001, 16'h3FFF, 16'h0000, 16'h7FFF};
	logic [31:0] e_hi [6] = '{32'hFFFFFFFF, 32'hFFFFFF00, 32'hFFFFFFFF, 32'hFFFFFF00, 32'h0, 32'h0};
	logic [31:0] e_lo [6] = '{32'hFFFFFFFF, 32'h0, 32'hFFFFF800, 32'h0, 32'h0, 32'h0};
	logic [10:0] c_row [10] = '{11'h679, 11'h675, 11'h672, 11'h701, 11'h600, 11'h181, 11'h090, 11'h111,
		11'h7C0, 11'h490};
	always #12.5 clk_in = ~clk_in;
	fpd_iu_model iu_u();
	fpd_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy_out(busy_out));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// only the watchdog ends a wait that never gets its answer
		forever begin
			@(posedge clk_in);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		bresp_q = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		forever begin
			@(posedge clk_in);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		rd_q = rdata;
		rr_q = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// start an instruction; the status word lands in rd_q
	task automatic go(input logic [31:0] w);
		wr(fpd_pkg::OFF_WORD, w);
		wr(fpd_pkg::OFF_CTRL, 32'h1);
		repeat (3) @(posedge clk_in);
		rd(fpd_pkg::OFF_STATUS);
	endtask
	task automatic idle();
		int n;
		for (n = 0; n < 20 && busy_out !== 1'b0; n++) @(posedge clk_in);
		chk({31'h0, busy_out}, 32'h0);
	endtask
	task automatic src(input logic [31:0] hi, input logic [31:0] lo, input logic [15:0] ex);
		wr(fpd_pkg::OFF_SRC_HI, hi);
		wr(fpd_pkg::OFF_SRC_LO, lo);
		wr(fpd_pkg::OFF_SRC_EXP, {16'h0, ex});
		wr(fpd_pkg::OFF_FPSR, 32'h00FFFF00);
	endtask
	task automatic complete_run();
		$display("errors=%0d checks=%0d", err_count, total_checks);
		if (err_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		complete_run();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		int i;
		int j;
		logic [10:0] r;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		wr(8'h34, 32'h1);
		chk({30'h0, bresp_q}, {30'h0, fpd_pkg::BRESP_SLVERR});
		rd(8'h40);
		chk({rd_q[31:2], rr_q}, {30'h0, fpd_pkg::BRESP_SLVERR});
		// negate: sign flip, rounding by opmode and by control precision
		for (i = 0; i < 6; i++) begin
			wr(fpd_pkg::OFF_FPCR, (i == 3) ? 32'h40 : 32'h0);
			src((i < 4) ? 32'hFFFFFFFF : 32'h0, (i < 4) ? 32'hFFFFFFFF : 32'h0, n_ex[i]);
			go(iu_u.arith(1'b1, fpd_pkg::FMT_EXT, 3'h0, n_op[i], 3'h2, 3'h0));
			chk(rd_q & 32'hF, 32'h1);
			rd(fpd_pkg::OFF_RES_HI);
			chk(rd_q, e_hi[i]);
			rd(fpd_pkg::OFF_RES_LO);
			chk(rd_q, e_lo[i]);
			rd(fpd_pkg::OFF_RES_EXP);
			chk(rd_q, {16'h0, n_ex[i] ^ 16'h8000});
			rd(fpd_pkg::OFF_FPSR);
			chk(rd_q & 32'h00FFBF00, 32'h00FF0000);
		end
		// multiply: infinity times a zero destination, each opmode, then one times a zero destination
		wr(fpd_pkg::OFF_FPCR, 32'h0);
		for (i = 0; i < 3; i++) begin
			src(32'h0, 32'h0, 16'h7FFF);
			go(iu_u.arith(1'b1, fpd_pkg::FMT_EXT, 3'(i + 1),
				(i == 0) ? fpd_pkg::OP_MUL : (i == 1) ? fpd_pkg::OP_MUL_S : fpd_pkg::OP_MUL_D, 3'h2, 3'h0));
			chk(rd_q & 32'hF, 32'h9);
			rd(fpd_pkg::OFF_RES_HI);
			chk(rd_q, 32'hFFFFFFFF);
			rd(fpd_pkg::OFF_RES_EXP);
			chk(rd_q & 32'h7FFF, 32'h7FFF);
			rd(fpd_pkg::OFF_FPSR);
			chk(rd_q & 32'h00FFA400, 32'h00FF2000);
		end
		src(32'h80000000, 32'h0, 16'h3FFF);
		go(iu_u.arith(1'b1, fpd_pkg::FMT_EXT, 3'h6, fpd_pkg::OP_MUL, 3'h2, 3'h0));
		chk(rd_q & 32'hF, 32'h1);
		rd(fpd_pkg::OFF_RES_HI);
		chk(rd_q, 32'h0);
		rd(fpd_pkg::OFF_FPSR);
		chk(rd_q & 32'h00FFA400, 32'h00FF0000);
		// source formats through memory and data register, then address register
		for (j = 0; j < 2; j++) begin
			for (i = 0; i < 7; i++) begin
				if (j == 1 && i == 3) continue;
				go(iu_u.arith(1'b1, 3'(i), 3'h7, fpd_pkg::OP_MUL, j ? 3'h0 : 3'h2, 3'h1));
				chk({30'h0, rd_q[2:1]}, {30'h0, j == 0 && i == 3, j == 1 && (i == 2 || i == 5)});
			end
		end
		go(iu_u.arith(1'b1, fpd_pkg::FMT_LONG, 3'h7, fpd_pkg::OP_MUL, 3'h1, 3'h0));
		chk({31'h0, rd_q[1]}, 32'h1);
		// control moves: addressing legality by direction and mask
		for (i = 0; i < 10; i++) begin
			r = c_row[i];
			go(iu_u.ctrl(r[10], r[9:7], r[6:4], r[3:1]));
			chk({31'h0, rd_q[1]}, {31'h0, r[0]});
			if (!r[0])
				for (j = 0; j < $countones(r[9:7]); j++) wr(fpd_pkg::OFF_XFER, 32'h0);
			idle();
		end
		// full load in fixed order, then store one back
		go(iu_u.ctrl(1'b0, 3'h7, 3'h2, 3'h0));
		rd(fpd_pkg::OFF_XFER);
		chk(rd_q & 32'h7, 32'h7);
		wr(fpd_pkg::OFF_XFER, 32'h00000030);
		wr(fpd_pkg::OFF_XFER, 32'h0F0F0000);
		wr(fpd_pkg::OFF_XFER, 32'h00ABCDEC);
		idle();
		rd(fpd_pkg::OFF_FPCR);
		chk(rd_q, 32'h00000030);
		rd(fpd_pkg::OFF_FPSR);
		chk(rd_q, 32'h0F0F0000);
		rd(fpd_pkg::OFF_FPIAR);
		chk(rd_q, 32'h00ABCDEC);
		go(iu_u.ctrl(1'b1, 3'h2, 3'h7, 3'h0));
		wr(fpd_pkg::OFF_XFER, 32'h5A5A5A5A);
		idle();
		rd(fpd_pkg::OFF_RES_LO);
		chk(rd_q, 32'h0F0F0000);
		rd(fpd_pkg::OFF_FPSR);
		chk(rd_q, 32'h0F0F0000);
		complete_run();
	end
endmodule
`default_nettype wire
